//--- src/sam_dev.sv
`timescale 1ns/1ps
module sam_dev #(
    parameter int CHANNELS = sam_pkg::CH_DEFAULT
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link
    sam_link_if.dev link,
    // Analog inputs as codes
    input wire logic [sam_pkg::NCH_MAX-1:0][sam_pkg::RES_W-1:0] ain,
    input wire logic [sam_pkg::RES_W-1:0] com_in,
    // Result
    output logic [sam_pkg::RES_W-1:0] result,
    output logic result_valid
);
    import sam_pkg::*;

    localparam int AB = addr_bits(CHANNELS);
    localparam int ALIGN = ADDR_W - AB;
    localparam logic [CNT_W-1:0] ADDR_LAST = CNT_W'(AB - 1);
    localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_BITS - 1);
    localparam logic [CNT_W-1:0] LSB_LAST = CNT_W'(LSB_BITS - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
    localparam logic [LSB_BITS-1:0] LSB_ZERO = 7'h00;

    sam_dst_t state_ff, nxt_state;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [ADDR_W-1:0] addr_ff, nxt_addr;
    logic [RES_W-1:0] diff_ff, nxt_diff;
    logic [RES_W-1:0] res_ff, nxt_res;
    logic [RES_W-1:0] trial_ff, nxt_trial;
    logic [LSB_BITS-1:0] lsb_sr_ff, nxt_lsb_sr;
    logic dout_ff, nxt_dout;
    logic oe_ff, nxt_oe;
    logic act_ff, nxt_act;
    logic valid_ff, nxt_valid;
    logic sclk_q_ff;

    logic rise;
    logic fall;
    logic [2:0] pos_idx;
    logic [2:0] neg_idx;
    logic [1:0] pair;
    logic [RES_W-1:0] pos_v;
    logic [RES_W-1:0] neg_v;
    logic [RES_W-1:0] diff_now;
    logic [RES_W-1:0] probe;
    logic cmp;
    logic lsb_go;

    assign rise = link.sclk & ~sclk_q_ff;
    assign fall = ~link.sclk & sclk_q_ff;

    // Mux decode from the latched address
    always_comb begin
        pair = 2'b00;
        if (CHANNELS == 8) begin
            pair = {addr_ff[F_SEL1], addr_ff[F_SEL0]};
        end else if (CHANNELS == 4) begin
            pair = {1'b0, addr_ff[F_SEL1]};
        end
        pos_idx = {pair, addr_ff[F_ODD]};
        neg_idx = {pair, ~addr_ff[F_ODD]};
        if (CHANNELS == 1) begin
            pos_idx = 3'h0;
            neg_idx = 3'h1;
        end
        pos_v = ain[pos_idx];
        if (CHANNELS != 1 && addr_ff[F_SGL]) begin
            // Smaller parts tie common to ground
            neg_v = (CHANNELS == 8) ? com_in : RES_ZERO;
        end else begin
            neg_v = ain[neg_idx];
        end
        diff_now = (pos_v > neg_v) ? pos_v - neg_v : RES_ZERO;
    end

    // Successive approximation step against the held difference
    assign probe = res_ff | trial_ff;
    assign cmp = diff_ff >= probe;
    // Eight-channel part waits for shift enable; others run on
    assign lsb_go = (CHANNELS == 8) ? ~link.lsb_first_shift_n : 1'b1;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_addr = addr_ff;
        nxt_diff = diff_ff;
        nxt_res = res_ff;
        nxt_trial = trial_ff;
        nxt_lsb_sr = lsb_sr_ff;
        nxt_dout = dout_ff;
        nxt_oe = oe_ff;
        nxt_act = act_ff;
        nxt_valid = valid_ff;
        if (link.cs_n) begin
            nxt_state = SAM_D_IDLE;
            nxt_cnt = CNT_ZERO;
            nxt_addr = ADDR_RST;
            nxt_diff = RES_ZERO;
            nxt_res = RES_ZERO;
            nxt_trial = TRIAL_INIT;
            nxt_lsb_sr = LSB_ZERO;
            nxt_dout = 1'b0;
            nxt_oe = 1'b0;
            nxt_act = 1'b0;
            nxt_valid = 1'b0;
        end else begin
            if (rise && act_ff && (state_ff == SAM_D_LSB || state_ff == SAM_D_TAIL)) begin
                nxt_act = 1'b0;
            end
            unique case (state_ff)
                SAM_D_IDLE: begin
                    if (rise) begin
                        if (AB == 0) begin
                            nxt_state = SAM_D_SETTLE;
                        end else if (link.serial_in) begin
                            nxt_state = SAM_D_ADDR;
                            nxt_cnt = CNT_ZERO;
                        end
                    end
                end
                SAM_D_ADDR: begin
                    if (rise) begin
                        nxt_addr = {addr_ff[ADDR_W-2:0], link.serial_in};
                        nxt_cnt = cnt_ff + 5'h01;
                        if (cnt_ff == ADDR_LAST) begin
                            nxt_addr = nxt_addr << ALIGN;
                            nxt_state = SAM_D_SETTLE;
                        end
                    end
                end
                SAM_D_SETTLE: begin
                    if (fall) begin
                        // Input is ignored from here on
                        nxt_diff = diff_now;
                        nxt_dout = 1'b0;
                        nxt_oe = 1'b1;
                        nxt_act = 1'b1;
                        nxt_cnt = CNT_ZERO;
                        nxt_state = SAM_D_CONV;
                    end
                end
                SAM_D_CONV: begin
                    if (fall) begin
                        nxt_dout = cmp;
                        nxt_res = cmp ? probe : res_ff;
                        nxt_trial = trial_ff >> 1;
                        nxt_cnt = cnt_ff + 5'h01;
                        if (cnt_ff == CONV_LAST) begin
                            nxt_cnt = CNT_ZERO;
                            nxt_valid = 1'b1;
                            nxt_lsb_sr = nxt_res[RES_W-1:1];
                            nxt_state = (CHANNELS == 1) ? SAM_D_TAIL : SAM_D_LSB;
                        end
                    end
                end
                SAM_D_LSB: begin
                    if (fall && lsb_go) begin
                        nxt_dout = lsb_sr_ff[0];
                        nxt_lsb_sr = lsb_sr_ff >> 1;
                        nxt_cnt = cnt_ff + 5'h01;
                        if (cnt_ff == LSB_LAST) begin
                            nxt_state = SAM_D_TAIL;
                        end
                    end
                end
                SAM_D_TAIL: begin
                    if (fall) begin
                        nxt_dout = 1'b0;
                    end
                end
                default: begin
                    nxt_state = SAM_D_IDLE;
                end
            endcase
        end
        // Stages that a smaller part does not load; not while shifting, or loaded bits get overwritten
        if (CHANNELS == 4 && nxt_state != SAM_D_ADDR) begin
            nxt_addr[F_SEL0] = 1'b1;
        end else if (CHANNELS == 2 && nxt_state != SAM_D_ADDR) begin
            nxt_addr[F_SEL0] = 1'b0;
            nxt_addr[F_SEL1] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= SAM_D_IDLE;
            cnt_ff <= CNT_ZERO;
            addr_ff <= ADDR_RST;
            diff_ff <= RES_ZERO;
            res_ff <= RES_ZERO;
            trial_ff <= TRIAL_INIT;
            lsb_sr_ff <= LSB_ZERO;
            dout_ff <= 1'b0;
            oe_ff <= 1'b0;
            act_ff <= 1'b0;
            valid_ff <= 1'b0;
            sclk_q_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            addr_ff <= nxt_addr;
            diff_ff <= nxt_diff;
            res_ff <= nxt_res;
            trial_ff <= nxt_trial;
            lsb_sr_ff <= nxt_lsb_sr;
            dout_ff <= nxt_dout;
            oe_ff <= nxt_oe;
            act_ff <= nxt_act;
            valid_ff <= nxt_valid;
            sclk_q_ff <= link.sclk;
        end
    end

    assign link.dout = dout_ff;
    assign link.dout_oe = oe_ff;
    assign link.conversion_active = act_ff;
    assign result = res_ff;
    assign result_valid = valid_ff;
endmodule : sam_dev

//--- src/sam_pkg.sv
package sam_pkg;
    // Converter word
    localparam int RES_W = 8;
    localparam int CONV_BITS = 8;
    localparam int LSB_BITS = 7;
    localparam int NCH_MAX = 8;
    localparam int ADDR_W = 4;
    localparam int CH_DEFAULT = 8;
    localparam logic [RES_W-1:0] TRIAL_INIT = 8'h80;
    localparam logic [RES_W-1:0] RES_ZERO = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RST = 4'h0;
    // Address field positions after alignment
    localparam int F_SGL = 3;
    localparam int F_ODD = 2;
    localparam int F_SEL1 = 1;
    localparam int F_SEL0 = 0;
    // Serial clock timing
    localparam int CLK_MHZ = 50;
    localparam int SCLK_MAX_KHZ = 400;
    localparam int T_MIN_PHASE_NS = 1000;
    localparam int T_MAX_HIGH_NS = 60000;
    localparam int T_HALF_NS = 1250;
    localparam int HALF_CYC = (T_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam int DIV_W = 16;
    localparam int CNT_W = 5;
    // Register bus
    localparam int PADDR_W = 4;
    localparam int PDATA_W = 32;
    localparam logic [PADDR_W-1:0] OFS_CMD = 4'h0;
    localparam logic [PADDR_W-1:0] OFS_STAT = 4'h4;
    localparam logic [PADDR_W-1:0] OFS_RES = 4'h8;
    // Command word bits
    localparam int B_LSB = 0;
    localparam int B_SEL0 = 1;
    localparam int B_SEL1 = 2;
    localparam int B_ODD = 3;
    localparam int B_SGL = 4;
    localparam int B_GO = 8;
    // Status word bits; result word holds both orders
    localparam int B_BUSY = 0;
    localparam int B_DONE = 1;
    localparam int R_LSB = 8;

    // Address bits that follow the start bit
    function automatic int addr_bits(input int ch);
        if (ch == 8) begin
            return 4;
        end else if (ch == 4) begin
            return 3;
        end else if (ch == 2) begin
            return 2;
        end
        return 0;
    endfunction : addr_bits

    typedef enum logic [5:0] {
        SAM_D_IDLE = 6'b000001,
        SAM_D_ADDR = 6'b000010,
        SAM_D_SETTLE = 6'b000100,
        SAM_D_CONV = 6'b001000,
        SAM_D_LSB = 6'b010000,
        SAM_D_TAIL = 6'b100000
    } sam_dst_t;

    typedef enum logic [1:0] {
        SAM_H_IDLE = 2'b01,
        SAM_H_RUN = 2'b10
    } sam_hst_t;
endpackage : sam_pkg

//--- src/sam_link_if.sv
`timescale 1ns/1ps
interface sam_link_if;
    logic cs_n;
    logic sclk;
    logic serial_in;
    logic lsb_first_shift_n;
    logic dout;
    logic dout_oe;
    logic conversion_active;
    // Level seen on the data-out wire; undriven reads as low
    logic dout_line;
    assign dout_line = dout_oe & dout;

    modport dev (
        input cs_n,
        input sclk,
        input serial_in,
        input lsb_first_shift_n,
        output dout,
        output dout_oe,
        output conversion_active
    );
    modport host (
        output cs_n,
        output sclk,
        output serial_in,
        output lsb_first_shift_n,
        input dout,
        input dout_oe,
        input conversion_active,
        input dout_line
    );
endinterface : sam_link_if

//--- src/sam_host.sv
`timescale 1ns/1ps
module sam_host #(
    parameter int CHANNELS = sam_pkg::CH_DEFAULT,
    parameter int HALF_CYC = sam_pkg::HALF_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link
    sam_link_if.host link,
    // Register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sam_pkg::PADDR_W-1:0] paddr,
    input wire logic [sam_pkg::PDATA_W-1:0] pwdata,
    output logic [sam_pkg::PDATA_W-1:0] prdata,
    output logic pready
);
    import sam_pkg::*;

    localparam int AB = addr_bits(CHANNELS);
    localparam logic [CNT_W-1:0] K_MSB0 = CNT_W'(AB + 2);
    localparam logic [CNT_W-1:0] K_LSB0 = CNT_W'(AB + 1 + CONV_BITS);
    localparam logic [CNT_W-1:0] K_END = CNT_W'(AB + 2 + CONV_BITS);
    localparam logic [CNT_W-1:0] K_END_LSB = CNT_W'(AB + 2 + CONV_BITS + LSB_BITS);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;

    sam_hst_t state_ff, nxt_state;
    logic [DIV_W-1:0] div_ff, nxt_div;
    logic [CNT_W-1:0] rise_cnt_ff, nxt_rise_cnt;
    logic [CNT_W-1:0] total_ff, nxt_total;
    logic [ADDR_W:0] tx_sr_ff, nxt_tx_sr;
    logic [RES_W-1:0] msb_sr_ff, nxt_msb_sr;
    logic [RES_W-1:0] lsb_sr_ff, nxt_lsb_sr;
    logic sclk_ff, nxt_sclk;
    logic cs_n_ff, nxt_cs_n;
    logic si_ff, nxt_si;
    logic shn_ff, nxt_shn;
    logic lsbreq_ff, nxt_lsbreq;
    logic done_ff, nxt_done;
    logic [PDATA_W-1:0] prdata_ff, nxt_prdata;
    logic wr_go;

    // No wait states; read data is caught in the setup cycle
    assign pready = psel & penable;
    assign wr_go = psel & penable & pwrite & (paddr == OFS_CMD) & pwdata[B_GO];

    always_comb begin
        nxt_state = state_ff;
        nxt_div = div_ff;
        nxt_rise_cnt = rise_cnt_ff;
        nxt_total = total_ff;
        nxt_tx_sr = tx_sr_ff;
        nxt_msb_sr = msb_sr_ff;
        nxt_lsb_sr = lsb_sr_ff;
        nxt_sclk = sclk_ff;
        nxt_cs_n = cs_n_ff;
        nxt_si = si_ff;
        nxt_shn = shn_ff;
        nxt_lsbreq = lsbreq_ff;
        nxt_done = done_ff;
        nxt_prdata = prdata_ff;
        unique case (state_ff)
            SAM_H_IDLE: begin
                // A start written while a frame runs is dropped
                if (wr_go) begin
                    // Falling select starts a fresh conversion
                    nxt_cs_n = 1'b0;
                    nxt_done = 1'b0;
                    nxt_tx_sr = {1'b1, pwdata[B_SGL], pwdata[B_ODD], pwdata[B_SEL1], pwdata[B_SEL0]};
                    nxt_si = 1'b1;
                    nxt_lsbreq = pwdata[B_LSB] && (CHANNELS != 1);
                    nxt_total = nxt_lsbreq ? K_END_LSB : K_END;
                    nxt_rise_cnt = CNT_ZERO;
                    nxt_div = '0;
                    nxt_sclk = 1'b0;
                    nxt_shn = 1'b1;
                    nxt_state = SAM_H_RUN;
                end
            end
            SAM_H_RUN: begin
                nxt_div = div_ff + 16'h0001;
                if (div_ff == DIV_LAST) begin
                    // Even split of the period keeps the duty at half
                    nxt_div = '0;
                    nxt_sclk = ~sclk_ff;
                    if (!sclk_ff) begin
                        nxt_rise_cnt = rise_cnt_ff + 5'h01;
                        if (rise_cnt_ff >= K_MSB0 && rise_cnt_ff < K_END) begin
                            nxt_msb_sr = {msb_sr_ff[RES_W-2:0], link.dout};
                        end
                        if (rise_cnt_ff >= K_LSB0) begin
                            nxt_lsb_sr = {link.dout, lsb_sr_ff[RES_W-1:1]};
                        end
                        if (rise_cnt_ff == K_LSB0 && lsbreq_ff && CHANNELS == 8) begin
                            nxt_shn = 1'b0;
                        end
                    end else begin
                        nxt_tx_sr = {tx_sr_ff[ADDR_W-1:0], 1'b0};
                        nxt_si = tx_sr_ff[ADDR_W-1];
                        if (rise_cnt_ff == total_ff) begin
                            // Clock parks low between frames
                            nxt_cs_n = 1'b1;
                            nxt_shn = 1'b1;
                            nxt_si = 1'b0;
                            nxt_done = 1'b1;
                            nxt_state = SAM_H_IDLE;
                        end
                    end
                end
            end
            default: begin
                nxt_state = SAM_H_IDLE;
            end
        endcase
        if (psel && !penable && !pwrite) begin
            nxt_prdata = '0;
            if (paddr == OFS_STAT) begin
                nxt_prdata[B_BUSY] = (state_ff == SAM_H_RUN);
                nxt_prdata[B_DONE] = done_ff;
            end else if (paddr == OFS_RES) begin
                nxt_prdata[RES_W-1:0] = msb_sr_ff;
                nxt_prdata[R_LSB +: RES_W] = lsb_sr_ff;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= SAM_H_IDLE;
            div_ff <= '0;
            rise_cnt_ff <= CNT_ZERO;
            total_ff <= CNT_ZERO;
            tx_sr_ff <= '0;
            msb_sr_ff <= RES_ZERO;
            lsb_sr_ff <= RES_ZERO;
            sclk_ff <= 1'b0;
            cs_n_ff <= 1'b1;
            si_ff <= 1'b0;
            shn_ff <= 1'b1;
            lsbreq_ff <= 1'b0;
            done_ff <= 1'b0;
            prdata_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            div_ff <= nxt_div;
            rise_cnt_ff <= nxt_rise_cnt;
            total_ff <= nxt_total;
            tx_sr_ff <= nxt_tx_sr;
            msb_sr_ff <= nxt_msb_sr;
            lsb_sr_ff <= nxt_lsb_sr;
            sclk_ff <= nxt_sclk;
            cs_n_ff <= nxt_cs_n;
            si_ff <= nxt_si;
            shn_ff <= nxt_shn;
            lsbreq_ff <= nxt_lsbreq;
            done_ff <= nxt_done;
            prdata_ff <= nxt_prdata;
        end
    end

    assign link.cs_n = cs_n_ff;
    assign link.sclk = sclk_ff;
    assign link.serial_in = si_ff;
    assign link.lsb_first_shift_n = shn_ff;
    assign prdata = prdata_ff;
endmodule : sam_host

//--- testbench/sam_link_monitor.sv
`timescale 1ns/1ps
module sam_link_monitor #(
    parameter int HALF_CYC = 4
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic serial_in,
    input wire logic lsb_first_shift_n,
    input wire logic dout,
    input wire logic dout_oe,
    input wire logic conversion_active
);
    logic [15:0] act_cnt_ff;
    logic [15:0] nxt_act_cnt;

    default clocking mon_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Active window length; cleared so an aborted frame cannot skew the next
    always_comb begin
        nxt_act_cnt = conversion_active ? act_cnt_ff + 16'h0001 : 16'h0000;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_cnt_ff <= 16'h0000;
        end else begin
            act_cnt_ff <= nxt_act_cnt;
        end
    end

    property p_clear;
        cs_n |=> !dout_oe && !conversion_active;
    endproperty
    a_clear: assert property (p_clear) else $error("device not cleared by chip select");
    property p_addr_quiet;
        $fell(cs_n) |-> !dout_oe [*3];
    endproperty
    a_addr_quiet: assert property (p_addr_quiet) else $error("output driven during address");
    property p_settle;
        $rose(conversion_active) |-> dout_oe && !dout && !sclk;
    endproperty
    a_settle: assert property (p_settle) else $error("settle phase without leading zero");
    property p_active_len;
        $fell(conversion_active) && !cs_n |-> act_cnt_ff == 17 * HALF_CYC;
    endproperty
    a_active_len: assert property (p_active_len) else $error("conversion window length off");
    property p_dout_fall;
        $changed(dout) && dout_oe && $past(dout_oe) |-> !sclk;
    endproperty
    a_dout_fall: assert property (p_dout_fall) else $error("result bit moved while clock high");
    property p_duty;
        $rose(sclk) |-> sclk [*4] ##1 !sclk;
    endproperty
    a_duty: assert property (p_duty) else $error("serial clock high time wrong");
    property p_idle_low;
        cs_n |-> !sclk;
    endproperty
    a_idle_low: assert property (p_idle_low) else $error("serial clock high outside frame");
    property p_start;
        $fell(cs_n) |-> serial_in && !sclk;
    endproperty
    a_start: assert property (p_start) else $error("frame opened without start bit");
    property p_shift;
        cs_n |-> lsb_first_shift_n;
    endproperty
    a_shift: assert property (p_shift) else $error("shift enable low outside frame");
endmodule : sam_link_monitor

//--- testbench/serial_adc_mux_interface_test.sv
`timescale 1ns/1ps
module serial_adc_mux_interface_test;
    import sam_pkg::*;
    // Short half period keeps the run brief; device needs at least 2
    localparam int HC = 4;
    localparam int LIMIT = 30000;
    logic pclk;
    logic presetn;
    logic [NCH_MAX-1:0][RES_W-1:0] ain;
    logic [RES_W-1:0] com_in;
    logic psel, penable, pwrite, pready;
    logic [PADDR_W-1:0] paddr;
    logic [PDATA_W-1:0] pwdata, prdata, reset_rd;
    logic dev_valid;
    logic [RES_W-1:0] dev_res;
    int num_errors = 0;
    int check_count = 0;
    int cyc = 0;

    sam_link_if i_sam_link_if ();
    sam_dev #(.CHANNELS(8)) i_sam_dev (.pclk(pclk), .presetn(presetn), .link(i_sam_link_if.dev), .ain(ain),
        .com_in(com_in), .result(dev_res), .result_valid(dev_valid));
    sam_host #(.CHANNELS(8), .HALF_CYC(HC)) i_sam_host (.pclk(pclk), .presetn(presetn),
        .link(i_sam_link_if.host), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready));
    sam_link_monitor #(.HALF_CYC(HC)) i_sam_link_monitor (.pclk(pclk), .presetn(presetn),
        .cs_n(i_sam_link_if.cs_n), .sclk(i_sam_link_if.sclk), .serial_in(i_sam_link_if.serial_in),
        .lsb_first_shift_n(i_sam_link_if.lsb_first_shift_n), .dout(i_sam_link_if.dout),
        .dout_oe(i_sam_link_if.dout_oe), .conversion_active(i_sam_link_if.conversion_active));

    initial pclk = 1'b0;
    always #10 pclk = ~pclk;

    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    always @(posedge pclk) begin
        cyc++;
        if (cyc == LIMIT) begin
            num_errors++;
            complete_run();
        end
    end

    task automatic check_byte(input logic [RES_W-1:0] got, input logic [RES_W-1:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_byte

    task automatic check_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_bit

    // Positive minus negative, clamped; negative index below zero means common input
    function automatic logic [RES_W-1:0] diff_of(input int p, input int n);
        logic [RES_W-1:0] pv;
        logic [RES_W-1:0] nv;
        pv = ain[p];
        nv = (n < 0) ? com_in : ain[n];
        return (pv > nv) ? pv - nv : RES_ZERO;
    endfunction : diff_of

    // Setup cycle, then access until ready is seen high at a rising edge
    task automatic apb_write(input logic [PADDR_W-1:0] addr, input logic [PDATA_W-1:0] data);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= 1'b1;
        paddr <= addr;
        pwdata <= data;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb_write

    task automatic apb_read(input logic [PADDR_W-1:0] addr, output logic [PDATA_W-1:0] data);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= addr;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        data = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb_read

    // One frame; poke retries start mid-frame, which must be ignored
    task automatic convert(input logic [4:0] c, input logic poke, input logic [RES_W-1:0] exp);
        int n;
        logic [PDATA_W-1:0] rd;
        apb_write(OFS_CMD, PDATA_W'({1'b1, 3'h0, c}));
        apb_read(OFS_STAT, rd);
        check_bit(rd[B_BUSY], 1'b1);
        if (poke) begin
            repeat (20) @(posedge pclk);
            apb_write(OFS_CMD, PDATA_W'({1'b1, 3'h0, 5'h1f}));
        end
        n = 0;
        while (dev_valid !== 1'b1 && n < 4000) begin
            @(posedge pclk);
            #1;
            n++;
        end
        check_byte(dev_res, exp);
        n = 0;
        rd = '0;
        while (rd[B_DONE] !== 1'b1 && n < 400) begin
            apb_read(OFS_STAT, rd);
            n++;
        end
        check_bit(rd[B_DONE], 1'b1);
        check_bit(dev_valid, 1'b0);
        apb_read(OFS_RES, rd);
        check_byte(rd[RES_W-1:0], exp);
        if (c[0]) begin
            check_byte(rd[R_LSB +: RES_W], exp);
        end
        if (poke) begin
            apb_read(OFS_STAT, rd);
            check_bit(rd[B_BUSY], 1'b0);
        end
    endtask : convert

    task automatic test_single_ended();
        for (int ch = 0; ch < 8; ch++) begin
            convert({1'b1, ch[0], ch[2], ch[1], 1'b0}, 1'b0, diff_of(ch, -1));
        end
    endtask : test_single_ended

    task automatic test_differential();
        for (int k = 0; k < 8; k++) begin
            convert({1'b0, k[0], k[2], k[1], k[0]}, 1'b0, diff_of(k, k ^ 1));
        end
    endtask : test_differential

    task automatic test_full_scale();
        @(posedge pclk);
        com_in <= RES_ZERO;
        ain[7] <= 8'hff;
        ain[0] <= 8'h00;
        convert(5'h1f, 1'b0, 8'hff);
        convert(5'h11, 1'b1, 8'h00);
    endtask : test_full_scale

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        com_in = 8'h30;
        for (int i = 0; i < NCH_MAX; i++) begin
            ain[i] = RES_W'(19 + 32 * i);
        end
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb_read(OFS_STAT, reset_rd);
        check_bit(reset_rd[B_BUSY], 1'b0);
        check_bit(reset_rd[B_DONE], 1'b0);
        test_single_ended();
        test_differential();
        test_full_scale();
        complete_run();
    end
endmodule : serial_adc_mux_interface_test
